// *** design/byte_move_pkg.sv ***
`default_nettype none
package byte_move_pkg;

   // Extension prefix nibble that opens the prefixed table.
   localparam logic [3:0] EXT_PREFIX = 4'h2;

   // Main opcode nibbles, shared by the plain and the prefixed table.
   localparam logic [3:0] OP_STATUS = 4'h1;
   localparam logic [3:0] OP_IMM = 4'h8;
   localparam logic [3:0] OP_MOVE_RR = 4'ha;
   localparam logic [3:0] OP_LD_AREG = 4'hc;
   localparam logic [3:0] OP_LD_AREG_D = 4'hd;
   localparam logic [3:0] OP_LD_STK_D = 4'h4;
   localparam logic [3:0] OP_LD_STK_D16 = 4'h0;
   localparam logic [3:0] OP_LD_IO = 4'h6;
   localparam logic [3:0] OP_LD_ABS = 4'h7;
   localparam logic [3:0] OP_LD_ABS12 = 4'h3;
   localparam logic [3:0] OP_ST_AREG = 4'he;
   localparam logic [3:0] OP_ST_AREG_D = 4'hf;
   localparam logic [3:0] OP_ST_STK_D = 4'h5;

   // Fixed base of the peripheral register page.
   localparam logic [15:0] IO_AREA_BASE = 16'h3f00;

   // Field nibble layout: destination low, source high, address select.
   localparam int DEST_LSB = 0;
   localparam int SRC_RR_LSB = 2;
   localparam int AREG_BIT = 2;

   // Payload nibbles kept; any further payload nibble is discarded.
   localparam logic [2:0] PAYLOAD_SLOTS = 3'h4;
   // Execute cycle in which load data are present on the memory bus.
   localparam logic [2:0] LOAD_DATA_CYCLE = 3'h2;

   // Kind of transfer the execute stage performs.
   typedef enum logic [2:0] {
      k_rr = 3'h0,
      k_imm = 3'h1,
      k_stat_w = 3'h2,
      k_stat_r = 3'h3,
      k_load = 3'h4,
      k_store = 3'h5
   } kind_t;

   // Base that the payload is added to when forming an address.
   typedef enum logic [1:0] {
      b_areg = 2'h0,
      b_stk = 2'h1,
      b_io = 2'h2,
      b_abs = 2'h3
   } base_t;

   // Everything the decoder needs to know about one instruction form.
   typedef struct packed {
      logic valid;
      logic [2:0] units;
      logic [2:0] cycles;
      kind_t kind;
      base_t base;
   } form_t;

   // Builds a valid form entry.
   function automatic form_t mk(input logic [2:0] u, input logic [2:0] c,
                                input kind_t k, input base_t b);
      form_t f;
      f.valid = 1'b1;
      f.units = u;
      f.cycles = c;
      f.kind = k;
      f.base = b;
      return f;
   endfunction : mk

   // Length in code units and cycle count of every supported form.
   function automatic form_t form_info(input logic ext, input logic [3:0] op);
      form_t f;
      f = '0;
      if (!ext) begin
         case (op)
            OP_MOVE_RR: f = mk(3'h2, 3'h1, k_rr, b_abs);
            OP_IMM: f = mk(3'h4, 3'h2, k_imm, b_abs);
            OP_STATUS: f = mk(3'h3, 3'h2, k_stat_r, b_abs);
            OP_LD_AREG: f = mk(3'h2, 3'h2, k_load, b_areg);
            OP_LD_AREG_D: f = mk(3'h4, 3'h2, k_load, b_areg);
            OP_LD_STK_D: f = mk(3'h3, 3'h2, k_load, b_stk);
            OP_LD_STK_D16: f = mk(3'h7, 3'h4, k_load, b_stk);
            OP_LD_IO: f = mk(3'h4, 3'h2, k_load, b_io);
            OP_LD_ABS: f = mk(3'h4, 3'h2, k_load, b_abs);
            OP_LD_ABS12: f = mk(3'h5, 3'h2, k_load, b_abs);
            OP_ST_AREG: f = mk(3'h2, 3'h2, k_store, b_areg);
            OP_ST_AREG_D: f = mk(3'h4, 3'h2, k_store, b_areg);
            OP_ST_STK_D: f = mk(3'h3, 3'h2, k_store, b_stk);
            default: f = '0;
         endcase
      end else begin
         case (op)
            OP_STATUS: f = mk(3'h3, 3'h3, k_stat_w, b_abs);
            OP_LD_AREG_D: f = mk(3'h7, 3'h4, k_load, b_areg);
            OP_LD_STK_D: f = mk(3'h5, 3'h3, k_load, b_stk);
            OP_LD_ABS: f = mk(3'h7, 3'h4, k_load, b_abs);
            OP_ST_AREG_D: f = mk(3'h7, 3'h4, k_store, b_areg);
            default: f = '0;
         endcase
      end
      return f;
   endfunction : form_info

endpackage : byte_move_pkg
`default_nettype wire

// *** design/exec_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// Hand-off of one fully fetched instruction from fetch to execute.
interface exec_if;
   logic ins_valid; // A complete instruction is held.
   logic ins_done; // Execute finished it; fetch may refill.
   logic [3:0] field; // Register select nibble.
   logic [15:0] payload; // Immediate, displacement or address.
   byte_move_pkg::form_t form; // Decoded form of the instruction.
   modport fetch (output ins_valid, field, payload, form, input ins_done);
   modport exec (input ins_valid, field, payload, form, output ins_done);
endinterface : exec_if
`default_nettype wire

// *** design/code_unit_fetch.sv ***
`timescale 1ns/1ns
`default_nettype none
// Collects code units in order and holds one instruction for execute.
module code_unit_fetch (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] code_nibble,
   input wire logic code_valid,
   output logic code_ready,
   output logic illegal_op,
   exec_if.fetch ins
);
   logic [2:0] unit_reg; // Code units of this instruction taken so far.
   logic ext_reg; // The prefix nibble has been seen.
   logic full_reg; // An instruction waits for execute.
   logic illegal_reg; // One-cycle flag for an unknown opcode.
   logic [3:0] field_reg;
   logic [15:0] payload_reg;
   byte_move_pkg::form_t form_reg;
   byte_move_pkg::form_t look;
   logic take, is_prefix, op_slot, last;
   logic [2:0] pay_idx;

   // No prefetch: the slot is single, so fetch stalls while execute runs.
   assign code_ready = !full_reg;
   assign take = code_valid && code_ready;
   // The prefix can only stand in the very first unit.
   assign is_prefix = (unit_reg == 3'h0) && (code_nibble ==
                      byte_move_pkg::EXT_PREFIX);
   assign op_slot = (unit_reg == {2'h0, ext_reg}) && !is_prefix;
   assign look = byte_move_pkg::form_info(ext_reg, code_nibble);
   // The opcode unit is never last, since every form has a field unit.
   assign last = !op_slot && !is_prefix &&
                 (unit_reg + 3'h1 == form_reg.units);
   assign pay_idx = unit_reg - {2'h0, ext_reg} - 3'h2;

   // Unit counter, prefix flag and slot occupancy.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_reg <= 3'h0;
         ext_reg <= 1'b0;
         full_reg <= 1'b0;
      end else begin
         if (take) begin
            if (is_prefix) begin
               // Prefix first, main opcode in the next unit.
               ext_reg <= 1'b1;
               unit_reg <= 3'h1;
            end else if (op_slot && !look.valid) begin
               // Unknown opcode: drop it and start over.
               ext_reg <= 1'b0;
               unit_reg <= 3'h0;
            end else if (last) begin
               ext_reg <= 1'b0;
               unit_reg <= 3'h0;
               full_reg <= 1'b1;
            end else begin
               unit_reg <= unit_reg + 3'h1;
            end
         end
         // Execute clears the slot; fetch is stalled then, so no clash.
         if (ins.ins_done) begin
            full_reg <= 1'b0;
         end
      end
   end

   // Capture of opcode form, field nibble and payload nibbles.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         form_reg <= '0;
         field_reg <= 4'h0;
         payload_reg <= 16'h0000;
      end else if (take && op_slot) begin
         form_reg <= look;
         payload_reg <= 16'h0000;
      end else if (take && !is_prefix &&
                   unit_reg == {2'h0, ext_reg} + 3'h1) begin
         field_reg <= code_nibble;
      end else if (take && !is_prefix &&
                   pay_idx < byte_move_pkg::PAYLOAD_SLOTS) begin
         // Payload arrives low nibble first.
         payload_reg[{pay_idx[1:0], 2'b00} +: 4] <= code_nibble;
      end
   end

   // Pulse that reports a discarded opcode.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         illegal_reg <= 1'b0;
      end else begin
         illegal_reg <= take && op_slot && !look.valid;
      end
   end

   assign illegal_op = illegal_reg;
   assign ins.ins_valid = full_reg;
   assign ins.field = field_reg;
   assign ins.payload = payload_reg;
   assign ins.form = form_reg;
endmodule : code_unit_fetch
`default_nettype wire

// *** design/byte_move_instruction_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module byte_move_instruction_decode (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] code_nibble,
   input wire logic code_valid,
   output logic code_ready,
   input wire logic [15:0] address_reg_0,
   input wire logic [15:0] address_reg_1,
   input wire logic [15:0] stack_pointer,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   output logic [31:0] data_regs,
   output logic [7:0] processor_status_word,
   output logic instr_done,
   output logic illegal_op
);
   // Execute sequencer states.
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_exec = 2'b10
   } state_t;

   exec_if x (); // Link between fetch and execute.
   state_t state_reg; // Sequencer state.
   logic [2:0] cnt_reg; // Execute cycle number, counted from one.
   logic [3:0][7:0] data_regs_reg; // The four data registers.
   logic [7:0] status_reg; // Status word.
   logic [15:0] mem_addr_reg;
   logic mem_rd_reg, mem_wr_reg;
   logic [7:0] mem_wdata_reg;
   logic start; // Execute takes the held instruction this cycle.
   logic [1:0] dest_sel, src_sel;
   logic [7:0] src_val; // Byte that a move, store or status write sends.
   logic [15:0] base_val, eff_addr;

   // Fetch side, owning the code unit port.
   code_unit_fetch fetch_u (
      .clk(clk),
      .rst_n(rst_n),
      .code_nibble(code_nibble),
      .code_valid(code_valid),
      .code_ready(code_ready),
      .illegal_op(illegal_op),
      .ins(x.fetch)
   );

   assign start = (state_reg == st_idle) && x.ins_valid;
   // Done is a handshake strobe and may be combinational.
   assign instr_done = (state_reg == st_exec) && (cnt_reg == x.form.cycles);
   assign x.ins_done = instr_done;

   // Register selects; a register move carries both in one nibble.
   assign dest_sel = x.field[byte_move_pkg::DEST_LSB +: 2];
   assign src_sel = (x.form.kind == byte_move_pkg::k_rr) ?
                    x.field[byte_move_pkg::SRC_RR_LSB +: 2] : dest_sel;
   assign src_val = data_regs_reg[src_sel];

   // Address base; plain register forms carry a zero payload.
   always_comb begin
      case (x.form.base)
         byte_move_pkg::b_areg: begin
            base_val = x.field[byte_move_pkg::AREG_BIT] ? address_reg_1 :
                       address_reg_0;
         end
         byte_move_pkg::b_stk: base_val = stack_pointer;
         byte_move_pkg::b_io: begin
            base_val = byte_move_pkg::IO_AREA_BASE;
         end
         default: base_val = 16'h0000;
      endcase
   end
   // Displacements are unsigned; the sum wraps in 16 bits.
   assign eff_addr = base_val + x.payload;

   // Sequencer: idle, then exactly the form's cycle count of execute.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= st_idle;
         cnt_reg <= 3'h0;
      end else begin
         case (state_reg)
            st_idle: begin
               if (start) begin
                  state_reg <= st_exec;
                  cnt_reg <= 3'h1;
               end
            end
            st_exec: begin
               if (instr_done) begin
                  state_reg <= st_idle;
                  cnt_reg <= 3'h0;
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            default: begin
               state_reg <= st_idle;
               cnt_reg <= 3'h0;
            end
         endcase
      end
   end

   // Memory strobes last one cycle: the first execute cycle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr_reg <= 16'h0000;
         mem_rd_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         mem_wdata_reg <= 8'h00;
      end else begin
         mem_rd_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         if (start && x.form.kind == byte_move_pkg::k_load) begin
            mem_rd_reg <= 1'b1;
            mem_addr_reg <= eff_addr;
         end else if (start && x.form.kind == byte_move_pkg::k_store) begin
            mem_wr_reg <= 1'b1;
            mem_addr_reg <= eff_addr;
            mem_wdata_reg <= src_val;
         end
      end
   end

   // Data register writes; read data are valid one cycle after the strobe.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_regs_reg <= '0;
      end else if (state_reg == st_exec) begin
         case (x.form.kind)
            byte_move_pkg::k_rr: begin
               if (instr_done) data_regs_reg[dest_sel] <= src_val;
            end
            byte_move_pkg::k_imm: begin
               if (instr_done) begin
                  data_regs_reg[dest_sel] <= x.payload[7:0];
               end
            end
            byte_move_pkg::k_stat_r: begin
               if (instr_done) data_regs_reg[dest_sel] <= status_reg;
            end
            byte_move_pkg::k_load: begin
               if (cnt_reg == byte_move_pkg::LOAD_DATA_CYCLE) begin
                  data_regs_reg[dest_sel] <= mem_rdata;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Status write replaces every flag at once.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= 8'h00;
      end else if (instr_done && x.form.kind == byte_move_pkg::k_stat_w) begin
         status_reg <= src_val;
      end
   end

   assign mem_addr = mem_addr_reg;
   assign mem_rd = mem_rd_reg;
   assign mem_wr = mem_wr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign data_regs = data_regs_reg;
   assign processor_status_word = status_reg;

   // Checks on timing and data paths of the execute stage. They all run on
   // the core clock and rest while reset is applied.
   default clocking chk_clk @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_rr_timing: assert property (
      start && x.form.kind == byte_move_pkg::k_rr |=> instr_done)
      else $error("register move not done in one cycle");
   a_imm_timing: assert property (
      start && x.form.kind == byte_move_pkg::k_imm |=>
      !instr_done ##1 instr_done)
      else $error("immediate load not done in two cycles");
   a_stat_wr_time: assert property (
      start && x.form.kind == byte_move_pkg::k_stat_w |=>
      !instr_done[*2] ##1 instr_done)
      else $error("status write not done in three cycles");
   a_stat_wr_value: assert property (
      instr_done && x.form.kind == byte_move_pkg::k_stat_w |=>
      processor_status_word == $past(src_val))
      else $error("status word not replaced by source");
   a_stat_rd_time: assert property (
      start && x.form.kind == byte_move_pkg::k_stat_r |-> ##2 instr_done)
      else $error("status read not done in two cycles");
   a_load_strobe: assert property (
      start && x.form.kind == byte_move_pkg::k_load |=>
      mem_rd && !mem_wr && mem_addr == $past(eff_addr) ##1 !mem_rd)
      else $error("load strobe or address wrong");
   a_io_address: assert property (
      start && x.form.base == byte_move_pkg::b_io |=>
      mem_addr == byte_move_pkg::IO_AREA_BASE + $past(x.payload))
      else $error("peripheral page address wrong");
   a_long_forms: assert property (
      start && x.form.cycles == 3'h4 |=> !instr_done[*3] ##1 instr_done)
      else $error("long form not done in four cycles");
   a_stk_byte_form: assert property (
      start && x.form.kind == byte_move_pkg::k_load && x.form.cycles == 3'h3
      |-> ##3 instr_done)
      else $error("stack byte load not done in three cycles");
   a_store_data: assert property (
      start && x.form.kind == byte_move_pkg::k_store |=>
      mem_wr && !mem_rd && mem_wdata == $past(src_val))
      else $error("store data wrong");
   a_done_single: assert property (
      instr_done |=> !instr_done)
      else $error("done held for two cycles");

   c_rr_move: cover property (@(posedge clk) disable iff (!rst_n)
      start && x.form.kind == byte_move_pkg::k_rr);
   c_long_load: cover property (@(posedge clk) disable iff (!rst_n)
      start && x.form.kind == byte_move_pkg::k_load && x.form.cycles == 3'h4);
   c_store: cover property (@(posedge clk) disable iff (!rst_n)
      mem_wr ##1 instr_done);
   c_illegal: cover property (@(posedge clk) disable iff (!rst_n) illegal_op);
endmodule : byte_move_instruction_decode
`default_nettype wire

// *** bench/data_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Byte-wide data memory on the far side of the decoder, no wait states.
module data_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   // Written bytes; unwritten places read a pattern of their address.
   logic [7:0] store_mem [logic [15:0]];

   // Contents of a place that was never written.
   function automatic logic [7:0] init_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction : init_val

   // Read data stand for one cycle only; otherwise the bus toggles so
   // that a sample one cycle late can never look like a match.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata <= 8'ha5;
      end else if (mem_rd) begin
         mem_rdata <= store_mem.exists(mem_addr) ? store_mem[mem_addr] :
                      init_val(mem_addr);
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end

   // Writes land at the strobe edge.
   always @(posedge clk) begin
      if (rst_n && mem_wr) begin
         store_mem[mem_addr] = mem_wdata;
      end
   end
endmodule : data_mem_model
`default_nettype wire

// *** bench/byte_move_instruction_decode_test.sv ***
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench: the driver queues notes, the monitor checks them.
module byte_move_instruction_decode_test;
   `define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin \
      failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
   // One expected instruction result.
   typedef struct {
      int n;
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wd;
      logic [31:0] regs;
      logic [7:0] status;
   } note_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] code_nibble = 4'h0;
   logic code_valid = 1'b0;
   logic code_ready, mem_rd, mem_wr, instr_done, illegal_op;
   logic [15:0] address_reg_0 = 16'h0000;
   logic [15:0] address_reg_1 = 16'h0000;
   logic [15:0] stack_pointer = 16'h0000;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata, processor_status_word;
   logic [31:0] data_regs;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   note_t q[$];
   note_t cur;
   logic [7:0] sh [4] = '{8'h00, 8'h00, 8'h00, 8'h00}; // Register mirror.
   logic [7:0] status_sh = 8'h00;
   logic [7:0] mm [logic [15:0]]; // Mirror of written memory.
   logic [7:0] ill_exp = 8'h00;
   logic [7:0] ill_seen = 8'h00;
   int cnt = 0;
   logic pend = 1'b0;
   logic seen_rd = 1'b0;
   logic seen_wr = 1'b0;
   logic [15:0] la = 16'h0000;
   logic [7:0] lw = 8'h00;

   byte_move_instruction_decode dut (.clk(clk), .rst_n(rst_n),
      .code_nibble(code_nibble), .code_valid(code_valid),
      .code_ready(code_ready), .address_reg_0(address_reg_0),
      .address_reg_1(address_reg_1), .stack_pointer(stack_pointer),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .data_regs(data_regs),
      .processor_status_word(processor_status_word),
      .instr_done(instr_done), .illegal_op(illegal_op));
   data_mem_model mem (.clk(clk), .rst_n(rst_n), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));

   // Free-running 100 MHz clock.
   initial begin
      forever #5 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // A hung handshake is cut short here.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end

   // Offers one code unit from a falling edge until it is taken.
   task automatic send(input logic [3:0] n);
      code_nibble = n;
      code_valid = 1'b1;
      while (code_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask : send

   // Same pattern as the memory model holds for unwritten places.
   function automatic logic [7:0] memv(input logic [15:0] a);
      return mm.exists(a) ? mm[a] : (a[7:0] ^ a[15:8] ^ 8'h5a);
   endfunction : memv

   // Issues one form with random field and payload, noting the result.
   // Kinds: 0 move, 1 immediate, 2 status write, 3 status read, 4 load,
   // 5 store. Bases: 0 address reg, 1 stack, 2 io page, 3 absolute.
   task automatic issue(input logic e, input logic [3:0] op, input int u,
                        input int c, input int k, input int b);
      logic [3:0] f;
      logic [19:0] p;
      logic [15:0] a, m;
      logic [1:0] d;
      int np;
      note_t nt;
      f = 4'($urandom);
      p = 20'($urandom);
      np = u - 2 - int'(e);
      d = f[1:0];
      // Address inputs change only while nothing executes.
      while (code_ready !== 1'b1) @(negedge clk);
      address_reg_0 = 16'($urandom);
      address_reg_1 = 16'($urandom);
      stack_pointer = 16'($urandom);
      m = (np >= 4) ? 16'hffff : 16'((1 << (4 * np)) - 1);
      case (b)
         0: a = (f[2] ? address_reg_1 : address_reg_0) + (p[15:0] & m);
         1: a = stack_pointer + (p[15:0] & m);
         2: a = byte_move_pkg::IO_AREA_BASE + {8'h00, p[7:0]};
         default: a = p[15:0] & m;
      endcase
      case (k)
         0: sh[d] = sh[f[3:2]];
         1: sh[d] = p[7:0];
         2: status_sh = sh[d];
         3: sh[d] = status_sh;
         4: sh[d] = memv(a);
         default: mm[a] = sh[d];
      endcase
      nt.n = c;
      nt.addr = a;
      nt.rd = (k == 4);
      nt.wr = (k == 5);
      nt.wd = sh[d];
      nt.regs = {sh[3], sh[2], sh[1], sh[0]};
      nt.status = status_sh;
      q.push_back(nt);
      if (e) send(byte_move_pkg::EXT_PREFIX);
      send(op);
      send(f);
      for (int i = 0; i < np; i++) send(p[4 * i +: 4]);
      code_valid = 1'b0;
   endtask : issue

   // Monitor: counts stalled cycles, records strobes, checks each result.
   always @(negedge clk) begin
      if (rst_n) begin
         if (pend) begin
            `CHK("regs", cur.regs, data_regs)
            `CHK("status", cur.status, processor_status_word)
            pend = 1'b0;
         end
         if (mem_rd === 1'b1) begin
            seen_rd = 1'b1;
            la = mem_addr;
         end
         if (mem_wr === 1'b1) begin
            seen_wr = 1'b1;
            la = mem_addr;
            lw = mem_wdata;
         end
         if (code_ready === 1'b0) cnt++;
         if (illegal_op === 1'b1) ill_seen++;
         if (instr_done === 1'b1) begin
            if (q.size() == 0) begin
               `CHK("unexpected done", 1'b0, 1'b1)
            end else begin
               cur = q.pop_front();
               `CHK("cycles", cur.n + 1, cnt)
               `CHK("read", cur.rd, seen_rd)
               `CHK("write", cur.wr, seen_wr)
               if (cur.rd || cur.wr) `CHK("addr", cur.addr, la)
               if (cur.wr) `CHK("wdata", cur.wd, lw)
               pend = 1'b1;
            end
            cnt = 0;
            seen_rd = 1'b0;
            seen_wr = 1'b0;
         end
      end
   end

   // Main sequence: every form three times, OP_LD_AREG six, then refused opcodes.
   initial begin
      void'($urandom(85811));
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      repeat (3) begin
         issue(0, byte_move_pkg::OP_IMM, 4, 2, 1, 3);
         issue(0, byte_move_pkg::OP_MOVE_RR, 2, 1, 0, 3);
         issue(1, byte_move_pkg::OP_STATUS, 3, 3, 2, 3);
         issue(0, byte_move_pkg::OP_STATUS, 3, 2, 3, 3);
         issue(0, byte_move_pkg::OP_LD_AREG, 2, 2, 4, 0);
         issue(0, byte_move_pkg::OP_LD_AREG_D, 4, 2, 4, 0);
         issue(1, byte_move_pkg::OP_LD_AREG_D, 7, 4, 4, 0);
         issue(0, byte_move_pkg::OP_LD_STK_D, 3, 2, 4, 1);
         issue(1, byte_move_pkg::OP_LD_STK_D, 5, 3, 4, 1);
         issue(0, byte_move_pkg::OP_LD_STK_D16, 7, 4, 4, 1);
         issue(0, byte_move_pkg::OP_LD_IO, 4, 2, 4, 2);
         issue(0, byte_move_pkg::OP_LD_ABS, 4, 2, 4, 3);
         issue(0, byte_move_pkg::OP_LD_ABS12, 5, 2, 4, 3);
         issue(1, byte_move_pkg::OP_LD_ABS, 7, 4, 4, 3);
         issue(0, byte_move_pkg::OP_ST_AREG, 2, 2, 5, 0);
         issue(0, byte_move_pkg::OP_ST_AREG_D, 4, 2, 5, 0);
         issue(1, byte_move_pkg::OP_ST_AREG_D, 7, 4, 5, 0);
         issue(0, byte_move_pkg::OP_ST_STK_D, 3, 2, 5, 1);
         issue(0, byte_move_pkg::OP_LD_AREG, 2, 2, 4, 0);
      end
      // Unknown plain and prefixed opcodes are dropped; fetch restarts.
      while (code_ready !== 1'b1) @(negedge clk);
      send(4'h9);
      code_valid = 1'b0;
      ill_exp++;
      @(negedge clk);
      send(byte_move_pkg::EXT_PREFIX);
      send(4'h8);
      code_valid = 1'b0;
      ill_exp++;
      @(negedge clk);
      issue(0, byte_move_pkg::OP_MOVE_RR, 2, 1, 0, 3);
      repeat (10) @(negedge clk);
      `CHK("illegal", ill_exp, ill_seen)
      `CHK("pending", 0, q.size())
      results();
   end
endmodule : byte_move_instruction_decode_test
`default_nettype wire
